/* core/pfr_spi_target.sv */
// SPI register target with CRC, write counter, key gate and fault alarms.
`timescale 1ns/100ps
`default_nettype none
module pfr_spi_target
    import pfr_pkg::*;
#(
    parameter int NF = NUM_FAULT
) (
    input  wire logic          clk,
    input  wire logic          rst_b,
    input  wire logic          serial_clock_in,
    input  wire logic          serial_select_n,
    input  wire logic          serial_data_in,
    output var  logic          serial_data_out,
    output logic               serial_data_out_oe,
    input  wire logic          crc_option,
    input  wire logic [NF-1:0] fault_raw,
    input  wire logic          fault_response_active,
    input  wire logic          reset_request_n,
    output var  logic          host_reset_out_n,
    output var  logic          interrupt_out_n,
    output var  logic          safety_alarm_out_n
);

    // ==========================================================
    // Reset bridge into the serial clock domain
    // The serial clock stops between frames, so its registers take an
    // asynchronous reset made here; release happens while it is idle.
    logic spi_rst;

    always_ff @(posedge clk) begin
        spi_rst <= ~rst_b;
    end

    // ==========================================================
    // Serial domain: frame state, cleared by deselect
    pfr_slot_t  slot;
    logic [2:0] bit_idx;
    logic [6:0] rx;
    logic       is_read;
    logic [9:0] addr;
    logic [7:0] crc;
    logic [7:0] wdata;
    logic [7:0] tx;

    // Serial domain: persistent state
    pfr_cfg_t   cfg;
    logic [7:0] issued_key;
    logic       key_ok;
    logic       unlock;
    logic [7:0] wcnt;
    logic [7:0] lfsr;
    logic [7:0] clr_bits;
    logic       clr_tog;
    logic       err_tog;
    logic [7:0] rec_s1;
    logic [7:0] rec_s2;
    logic       crc_s1;
    logic       crc_s2;

    // Clock domain state
    logic [7:0] rec;

    // ==========================================================
    // Serial domain decode
    wire        crc_en    = crc_s2;
    wire        byte_done = (bit_idx == 3'd7);
    wire [7:0]  rx_byte   = {rx, serial_data_in};
    wire        in_bit    = (is_read && slot == SLOT_DATA) ? tx[7] : serial_data_in;
    wire [7:0]  crc_upd   = pfr_crc_step(crc, in_bit);
    wire        wr_data_e = !is_read && byte_done && slot == SLOT_DATA && !crc_en;
    wire        wr_crc_e  = !is_read && byte_done && slot == SLOT_CRC;
    wire        crc_good  = (crc_upd == 8'h00);
    wire        wr_commit = wr_data_e || (wr_crc_e && crc_good);
    wire        crc_bad   = wr_crc_e && !crc_good;
    wire [7:0]  wr_data   = (slot == SLOT_CRC) ? wdata : rx_byte;
    wire        wr_prot   = (addr >= PROT_BASE);
    wire        wr_hit    = wr_commit && (!wr_prot || unlock);
    wire [9:0]  cmd_addr  = {addr[9:8], rx_byte};
    wire        key_read  = is_read && byte_done && slot == SLOT_CMD1 && cmd_addr == ADDR_KEY;
    wire        tx_load   = is_read && bit_idx == 3'd0 && (slot == SLOT_DATA || slot == SLOT_CRC);
    wire [7:0]  lfsr_next = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};

    logic [7:0] rd_data;
    pfr_slot_t  next_slot;

    always_comb begin
        if (addr == ADDR_CFG1) begin
            rd_data = cfg.cfg;
        end else if (addr == ADDR_INT_MASK) begin
            rd_data = cfg.int_mask;
        end else if (addr == ADDR_ALM_MASK) begin
            rd_data = cfg.alm_mask;
        end else if (addr == ADDR_DGL) begin
            rd_data = cfg.dgl;
        end else if (addr == ADDR_KEY) begin
            rd_data = issued_key;
        end else if (addr == ADDR_WCNT) begin
            rd_data = wcnt;
        end else if (addr == ADDR_RECORD) begin
            rd_data = rec_s2;
        end else begin
            rd_data = 8'h00;
        end
    end

    // Byte sequence of a frame: two command bytes, then data and CRC slots.
    always_comb begin
        case (slot)
            SLOT_CMD0: next_slot = SLOT_CMD1;
            SLOT_CMD1: next_slot = SLOT_DATA;
            SLOT_DATA: next_slot = crc_en ? SLOT_CRC : (is_read ? SLOT_DATA : SLOT_DONE);
            SLOT_CRC:  next_slot = is_read ? SLOT_DATA : SLOT_DONE;
            default:   next_slot = SLOT_DONE;
        endcase
    end

    // ==========================================================
    // Serial domain: rising-edge capture, frame ends on deselect
    always_ff @(posedge serial_clock_in or posedge serial_select_n) begin
        if (serial_select_n) begin
            slot    <= SLOT_CMD0;
            bit_idx <= 3'd0;
            rx      <= 7'h00;
            is_read <= 1'b0;
            addr    <= 10'h000;
            crc     <= CRC_INIT;
            wdata   <= 8'h00;
        end else begin
            bit_idx <= bit_idx + 3'd1;
            rx      <= rx_byte[6:0];
            crc     <= (byte_done && slot == SLOT_CRC) ? CRC_INIT : crc_upd;
            if (byte_done) begin
                slot <= next_slot;
                if (slot == SLOT_CMD0) begin
                    is_read    <= rx_byte[7];
                    addr[9:8]  <= rx_byte[1:0];
                end else if (slot == SLOT_CMD1) begin
                    addr[7:0]  <= rx_byte;
                end else if (slot == SLOT_DATA && is_read) begin
                    addr       <= addr + 10'd1;
                end else if (slot == SLOT_DATA) begin
                    wdata      <= rx_byte;
                end
            end
        end
    end

    // ==========================================================
    // Serial domain: falling-edge launch
    // Loading on the falling edge after a byte boundary gives the host a
    // full half period of setup before its next rising sample.
    always_ff @(negedge serial_clock_in or posedge serial_select_n) begin
        if (serial_select_n) begin
            tx <= 8'h00;
        end else if (tx_load) begin
            tx <= (slot == SLOT_CRC) ? crc : rd_data;
        end else begin
            tx <= {tx[6:0], 1'b0};
        end
    end

    assign serial_data_out    = tx[7];
    assign serial_data_out_oe = ~(cfg.cfg[CFG_FLOAT_BIT] & serial_select_n);

    // ==========================================================
    // Serial domain: register writes, key gate, counters
    always_ff @(posedge serial_clock_in or posedge spi_rst) begin
        if (spi_rst) begin
            cfg        <= '{cfg: CFG1_RST, int_mask: MASK_RST, alm_mask: MASK_RST, dgl: DGL_RST};
            issued_key <= 8'h00;
            key_ok     <= 1'b0;
            unlock     <= 1'b0;
            wcnt       <= 8'h00;
            lfsr       <= KEY_SEED;
            clr_bits   <= 8'h00;
            clr_tog    <= 1'b0;
            err_tog    <= 1'b0;
        end else begin
            lfsr <= lfsr_next;
            if (key_read) begin
                issued_key <= lfsr;
                key_ok     <= 1'b1;
            end
            if (crc_bad) begin
                err_tog <= ~err_tog;
            end
            if (wr_hit) begin
                wcnt <= wcnt + 8'd1;
            end
            if (wr_commit && addr == ADDR_KEY) begin
                unlock <= key_ok && (wr_data == issued_key);
                key_ok <= 1'b0;
            end else if (wr_commit && wr_prot) begin
                unlock <= 1'b0;
            end
            if (wr_hit && addr == ADDR_CFG1) begin
                cfg.cfg <= wr_data;
            end else if (wr_hit && addr == ADDR_INT_MASK) begin
                cfg.int_mask <= wr_data;
            end else if (wr_hit && addr == ADDR_ALM_MASK) begin
                cfg.alm_mask <= wr_data;
            end else if (wr_hit && addr == ADDR_DGL) begin
                cfg.dgl <= wr_data;
            end else if (wr_hit && addr == ADDR_RECORD) begin
                clr_bits <= wr_data;
                clr_tog  <= ~clr_tog;
            end
        end
    end

    // Record bits and the CRC option strap into the serial domain.
    always_ff @(posedge serial_clock_in or posedge spi_rst) begin
        if (spi_rst) begin
            rec_s1 <= 8'h00;
            rec_s2 <= 8'h00;
            crc_s1 <= 1'b0;
            crc_s2 <= 1'b0;
        end else begin
            rec_s1 <= rec;
            rec_s2 <= rec_s1;
            crc_s1 <= crc_option;
            crc_s2 <= crc_s1;
        end
    end

    a_wcnt_step: assert property (@(posedge serial_clock_in) disable iff (spi_rst)
        wr_hit |=> wcnt == $past(wcnt) + 8'd1)
        else $error("write counter did not advance");

    a_prot_block: assert property (@(posedge serial_clock_in) disable iff (spi_rst)
        wr_commit && wr_prot && !unlock |=> cfg == $past(cfg))
        else $error("locked protected register changed");

    a_key_single: assert property (@(posedge serial_clock_in) disable iff (spi_rst)
        wr_commit && wr_prot && addr != ADDR_KEY |=> !unlock)
        else $error("key unlock used more than once");

    // ==========================================================
    // Clock domain: crossings
    logic [2:0]      clr_sync;
    logic [2:0]      err_sync;
    pfr_cfg_t        cfg_s1;
    pfr_cfg_t        cfg_s2;
    logic [NF-1:0]   raw_s1;
    logic [NF-1:0]   raw_s2;
    logic [NF-1:0]   fault_q;

    // Configuration changes only at the last bit of a write's data or CRC byte, so a two-stage hold is
    // enough; the clear data is read only when its toggle has arrived.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            clr_sync <= 3'b000;
            err_sync <= 3'b000;
            cfg_s1   <= '{cfg: CFG1_RST, int_mask: MASK_RST, alm_mask: MASK_RST, dgl: DGL_RST};
            cfg_s2   <= '{cfg: CFG1_RST, int_mask: MASK_RST, alm_mask: MASK_RST, dgl: DGL_RST};
            raw_s1   <= '0;
            raw_s2   <= '0;
        end else begin
            clr_sync <= {clr_sync[1:0], clr_tog};
            err_sync <= {err_sync[1:0], err_tog};
            cfg_s1   <= cfg;
            cfg_s2   <= cfg_s1;
            raw_s1   <= fault_raw;
            raw_s2   <= raw_s1;
        end
    end

    wire clr_evt = clr_sync[2] ^ clr_sync[1];
    wire err_evt = err_sync[2] ^ err_sync[1];

    // ==========================================================
    // Clock domain: deglitch filters, one per source
    genvar gi;
    generate
        for (gi = 0; gi < NF; gi++) begin : g_dgl
            pfr_deglitch #(.W(8)) u_dgl (
                .clk       (clk),
                .rst_b     (rst_b),
                .abnormal  (raw_s2[gi]),
                .min_count (cfg_s2.dgl),
                .fault     (fault_q[gi])
            );
        end
    endgenerate

    // ==========================================================
    // Clock domain: records and alarm outputs
    // Response case programming is deliberately absent here: a record is
    // taken whatever reaction the sequencer applies.
    wire [7:0] rec_set = {err_evt, fault_q};
    wire [7:0] rec_clr = clr_evt ? clr_bits : 8'h00;
    wire       force_lo = fault_response_active & ~reset_request_n;
    wire       int_req = |(rec & ~cfg_s2.int_mask);
    wire       alm_req = |(rec & ~cfg_s2.alm_mask);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rec                <= 8'h00;
            interrupt_out_n    <= 1'b1;
            safety_alarm_out_n <= 1'b1;
            host_reset_out_n   <= 1'b1;
        end else begin
            rec                <= (rec & ~rec_clr) | rec_set;
            interrupt_out_n    <= ~(int_req | force_lo);
            safety_alarm_out_n <= ~(alm_req | force_lo);
            host_reset_out_n   <= reset_request_n;
        end
    end

    sequence s_crc_err;
        err_evt ##1 rec[CRC_REC_BIT];
    endsequence

    a_crc_record: assert property (@(posedge clk) disable iff (!rst_b)
        err_evt |-> s_crc_err)
        else $error("CRC error not recorded");

    a_rec_setwins: assert property (@(posedge clk) disable iff (!rst_b)
        rec_set != 8'h00 |=> (rec & $past(rec_set)) == $past(rec_set))
        else $error("record set lost to clear");

    a_rec_hold: assert property (@(posedge clk) disable iff (!rst_b)
        !clr_evt |=> (rec & $past(rec)) == $past(rec))
        else $error("record dropped without clear");

    a_int_assert: assert property (@(posedge clk) disable iff (!rst_b)
        int_req |=> !interrupt_out_n)
        else $error("interrupt not asserted for unmasked record");

    a_int_release: assert property (@(posedge clk) disable iff (!rst_b)
        !int_req && !force_lo |=> interrupt_out_n)
        else $error("interrupt held with nothing pending");

    a_int_forced: assert property (@(posedge clk) disable iff (!rst_b)
        force_lo [*2] |-> ##1 !interrupt_out_n && !safety_alarm_out_n)
        else $error("outputs not forced during reset response");

    a_alarm_follow: assert property (@(posedge clk) disable iff (!rst_b)
        1'b1 |=> safety_alarm_out_n == !($past(alm_req) || $past(force_lo)))
        else $error("safety alarm wrong");

endmodule
`default_nettype wire

/* inc/pfr_pkg.sv */
// Shared constants, types and the CRC step for the fault-report SPI target.
package pfr_pkg;

    // ==========================================================
    // Register map
    localparam logic [9:0] ADDR_KEY      = 10'h010;
    localparam logic [9:0] ADDR_WCNT     = 10'h011;
    localparam logic [9:0] ADDR_RECORD   = 10'h020;
    localparam logic [9:0] ADDR_CFG1     = 10'h200;
    localparam logic [9:0] ADDR_INT_MASK = 10'h201;
    localparam logic [9:0] ADDR_ALM_MASK = 10'h202;
    localparam logic [9:0] ADDR_DGL      = 10'h203;
    localparam logic [9:0] PROT_BASE     = 10'h200;

    // ==========================================================
    // Field positions and sizes
    localparam int NUM_FAULT     = 7;
    localparam int CRC_REC_BIT   = 7;
    localparam int CFG_FLOAT_BIT = 0;

    // ==========================================================
    // Reset values and the CRC polynomial
    localparam logic [7:0] CFG1_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] DGL_RST  = 8'h04;
    localparam logic [7:0] KEY_SEED = 8'hA5;
    localparam logic [7:0] CRC_INIT = 8'h00;
    localparam logic [7:0] CRC_POLY = 8'h07;

    // ==========================================================
    // Types
    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] int_mask;
        logic [7:0] alm_mask;
        logic [7:0] dgl;
    } pfr_cfg_t;

    typedef enum logic [2:0] {SLOT_CMD0, SLOT_CMD1, SLOT_DATA, SLOT_CRC, SLOT_DONE} pfr_slot_t;

    // One bit of CRC-8, polynomial 0x107, MSB first, no final inversion.
    function automatic logic [7:0] pfr_crc_step(input logic [7:0] c, input logic b);
        logic fb;
        fb = c[7] ^ b;
        return {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
    endfunction

endpackage

/* core/pfr_deglitch.sv */
// Minimum-duration filter that turns one abnormal level into a fault level.
`timescale 1ns/100ps
`default_nettype none
module pfr_deglitch
    import pfr_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         abnormal,
    input  wire logic [W-1:0] min_count,
    output var  logic         fault
);

    // ==========================================================
    // Duration counter
    logic [W-1:0] cnt;
    wire          cnt_max = &cnt;

    // The fault is raised only once the condition outlasts the minimum.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt   <= '0;
            fault <= 1'b0;
        end else begin
            cnt   <= !abnormal ? '0 : (cnt_max ? cnt : cnt + 1'b1);
            fault <= abnormal && (cnt >= min_count);
        end
    end

    a_dgl_minimum: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(fault) |-> $past(abnormal) && ($past(cnt) >= $past(min_count)))
        else $error("fault raised before minimum duration");

    a_dgl_drop: assert property (@(posedge clk) disable iff (!rst_b)
        !abnormal |=> !fault)
        else $error("fault stayed while condition absent");

endmodule
`default_nettype wire

/* tb/pfr_host_model.sv */
// SPI controller model that drives mode 0 frames on its own link clock.
`timescale 1ns/100ps
`default_nettype none
module pfr_host_model (
    output var logic serial_clock_in,
    output var logic serial_select_n,
    output var logic serial_data_in,
    input  wire logic serial_data_out
);
    logic [7:0] rx_byte;
    event       got;

    initial begin
        serial_clock_in = 1'b0;
        serial_select_n = 1'b1;
        serial_data_in  = 1'b0;
        rx_byte         = 8'h00;
    end

    // ==========================================================
    // Frame
    // The clock stands still between frames, and the data line is
    // inverted after release so that stale bits are never mistaken for data.
    task automatic xfer(input int n, input logic [63:0] tx, input bit chk,
                        output logic [63:0] rx);
        rx = '0;
        serial_select_n = 1'b0;
        #60;
        for (int i = n * 8 - 1; i >= 0; i--) begin
            serial_data_in = tx[i];
            #24 serial_clock_in = 1'b1;
            rx = {rx[62:0], serial_data_out};
            if (chk && i < n * 8 - 16 && i % 8 == 0) begin
                rx_byte = rx[7:0];
                -> got;
            end
            #24 serial_clock_in = 1'b0;
        end
        #60 serial_select_n = 1'b1;
        serial_data_in = ~serial_data_in;
        #480;
    endtask
endmodule
`default_nettype wire

/* tb/pfr_spi_target_test.sv */
// Self-checking bench for the fault-report SPI target.
`timescale 1ns/100ps
`default_nettype none
module pfr_spi_target_test;
    import pfr_pkg::*;
    logic        clk;
    logic        rst_b;
    logic        crc_option;
    logic [6:0]  fault_raw;
    logic        fra;
    logic        rrn;
    wire logic   sck;
    wire logic   ssn;
    wire logic   sdi;
    wire logic   sdo;
    wire logic   oe;
    wire logic   hro;
    wire logic   ino;
    wire logic   alo;
    logic [7:0]  exp_q[$];
    int          fail_count;
    int          tests_run;
    logic [31:0] seed;
    logic [63:0] rx;
    logic [7:0]  bv;
    logic [7:0]  bv2;

    pfr_spi_target pfr_spi_target_i (.clk(clk), .rst_b(rst_b), .serial_clock_in(sck),
        .serial_select_n(ssn), .serial_data_in(sdi), .serial_data_out(sdo),
        .serial_data_out_oe(oe), .crc_option(crc_option), .fault_raw(fault_raw),
        .fault_response_active(fra), .reset_request_n(rrn), .host_reset_out_n(hro),
        .interrupt_out_n(ino), .safety_alarm_out_n(alo));
    pfr_host_model pfr_host_model_i (.serial_clock_in(sck), .serial_select_n(ssn),
        .serial_data_in(sdi), .serial_data_out(sdo));

    // ==========================================================
    // Helpers
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
            fail_count++;
        end
    endtask

    task automatic conclude;
        if (fail_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    function automatic logic [7:0] crc8(input logic [31:0] v, input int nb);
        logic [7:0] c;
        c = 8'h00;
        for (int i = nb * 8 - 1; i >= 0; i--)
            c = (c[7] ^ v[i]) ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
        return c;
    endfunction

    task automatic wr(input logic [9:0] a, input logic [7:0] d, input bit bad);
        logic [23:0] f;
        f = {6'h00, a, d};
        if (crc_option)
            pfr_host_model_i.xfer(4, 64'({f, crc8(32'(f), 3) ^ {7'h00, bad}}), 0, rx);
        else
            pfr_host_model_i.xfer(3, 64'(f), 0, rx);
    endtask

    task automatic rd(input logic [9:0] a, input int n, input logic [31:0] d);
        logic [15:0] c;
        int          nb;
        c = {6'b100000, a};
        nb = 2 + n * (crc_option ? 2 : 1);
        for (int k = n - 1; k >= 0; k--) begin
            exp_q.push_back(d[k*8+:8]);
            if (crc_option)
                exp_q.push_back(k == n - 1 ? crc8(32'({c, d[k*8+:8]}), 3)
                                           : crc8(32'(d[k*8+:8]), 1));
        end
        pfr_host_model_i.xfer(nb, 64'(c) << (8 * (nb - 2)), 1, rx);
    endtask

    task automatic unlock;
        pfr_host_model_i.xfer(3, 64'({6'b100000, ADDR_KEY, 8'h00}), 0, rx);
        wr(ADDR_KEY, rx[7:0], 0);
    endtask

    task automatic waitc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // ==========================================================
    // Clock, watchdog and read-data checker
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        #500000;
        fail_count++;
        conclude();
    end

    initial forever begin
        @(pfr_host_model_i.got);
        check("read byte", pfr_host_model_i.rx_byte, exp_q.size() ? exp_q.pop_front() : 8'hXX);
    end

    // ==========================================================
    // Main sequence
    initial begin
        fail_count = 0;
        tests_run  = 0;
        rst_b      = 1'b0;
        crc_option = 1'b0;
        fault_raw  = 7'h00;
        fra        = 1'b0;
        rrn        = 1'b1;
        seed       = xs(32'hf83be929);
        bv         = 8'(1 << (seed % 7));
        bv2        = {1'b0, bv[5:0], bv[6]};
        repeat (6) @(posedge clk);
        @(negedge clk) rst_b = 1'b1;
        waitc(3);
        check("alarms", {5'h00, hro, ino, alo}, 8'h07);
        check("oe default", 8'(oe), 8'h01);
        rd(ADDR_WCNT, 1, 32'h00);
        wr(ADDR_CFG1, 8'h01, 0);
        rd(ADDR_CFG1, 1, 32'(CFG1_RST));
        unlock();
        wr(ADDR_CFG1, 8'h01, 0);
        wr(ADDR_CFG1, 8'h00, 0);
        rd(ADDR_CFG1, 4, {8'h01, MASK_RST, MASK_RST, DGL_RST});
        check("oe float", 8'(oe), 8'h00);
        rd(ADDR_WCNT, 1, 32'h02);
        @(negedge clk) fault_raw = bv[6:0];
        waitc(int'(DGL_RST) + 4);
        check("early", {6'h00, ino, alo}, 8'h03);
        waitc(1);
        check("fault", {6'h00, ino, alo}, 8'h00);
        wr(ADDR_RECORD, 8'hFF, 0);
        rd(ADDR_RECORD, 1, 32'(bv));
        @(negedge clk) fault_raw = 7'h00;
        waitc(8);
        wr(ADDR_RECORD, 8'h00, 0);
        rd(ADDR_RECORD, 1, 32'(bv));
        wr(ADDR_RECORD, bv, 0);
        check("cleared", {6'h00, ino, alo}, 8'h03);
        unlock();
        wr(ADDR_INT_MASK, bv, 0);
        @(negedge clk) fault_raw = bv[6:0];
        waitc(20);
        check("masked", {6'h00, ino, alo}, 8'h02);
        fra = 1'b1;
        rrn = 1'b0;
        waitc(3);
        check("forced", {5'h00, hro, ino, alo}, 8'h00);
        fra = 1'b0;
        rrn = 1'b1;
        fault_raw = 7'h00;
        waitc(3);
        check("release", {5'h00, hro, ino, alo}, 8'h06);
        wr(ADDR_RECORD, bv, 0);
        // A wrong key must keep the gate shut; then filter length and alarm mask change.
        pfr_host_model_i.xfer(3, 64'({6'b100000, ADDR_KEY, 8'h00}), 0, rx);
        wr(ADDR_KEY, ~rx[7:0], 0);
        wr(ADDR_DGL, 8'h08, 0);
        rd(ADDR_DGL, 1, 32'(DGL_RST));
        unlock();
        wr(ADDR_ALM_MASK, bv, 0);
        unlock();
        wr(ADDR_DGL, 8'h08, 0);
        @(negedge clk) fault_raw = bv[6:0] | bv2[6:0];
        waitc(12);
        check("dgl early", {6'h00, ino, alo}, 8'h03);
        waitc(1);
        check("dgl fault", {6'h00, ino, alo}, 8'h00);
        @(negedge clk) fault_raw = 7'h00;
        waitc(4);
        wr(ADDR_RECORD, bv2, 0);
        check("alarm mask", {6'h00, ino, alo}, 8'h03);
        wr(ADDR_RECORD, bv, 0);
        @(negedge clk) crc_option = 1'b1;
        pfr_host_model_i.xfer(1, 64'h00, 0, rx);
        rd(ADDR_CFG1, 2, {16'h00, 8'h01, bv});
        wr(ADDR_RECORD, 8'h00, 1);
        check("crc error", {6'h00, ino, alo}, 8'h00);
        wr(ADDR_RECORD, 8'h80, 1);
        rd(ADDR_RECORD, 1, 32'h80);
        wr(ADDR_RECORD, 8'h80, 0);
        check("crc clear", {6'h00, ino, alo}, 8'h03);
        rd(ADDR_WCNT, 1, 32'h10);
        check("queue", 8'(exp_q.size()), 8'h00);
        conclude();
    end
endmodule
`default_nettype wire
